// [hw/mctl_pkg.sv]
// machine-control instruction group: opcodes, layouts, reset values and carrier types
package mctl_pkg;
	// ----------------------------------------
	// opcodes (16-bit instruction words)
	// ----------------------------------------
	localparam logic [15:0] OPC_LOAD_IO_TRANSLATION = 16'h0024;
	localparam logic [15:0] OPC_LOAD_PROCESS_IDENTIFIER = 16'h018F;
	localparam logic [15:0] OPC_LEAVE_PAGING_JUMP = 16'h008D;
	localparam logic [15:0] OPC_LEAVE_PAGING_JUMP_CONTROL_STORE = 16'h009D;
	localparam logic [15:0] OPC_LOAD_STATUS_WORD = 16'h01C9;
	localparam logic [15:0] OPC_LOAD_CONTROL_STORE = 16'h03C8;
	localparam logic [15:0] OPC_CONTROL_STORE_CONTROL = 16'h03CC;
	localparam logic [15:0] OPC_NOP = 16'h0001;
	localparam logic [15:0] OPC_TRANSLATION_PURGE = 16'h0034;
	localparam logic [15:0] OPC_REGISTER_RESTORE = 16'h01CF;
	localparam logic [15:0] OPC_REGISTER_SAVE = 16'h01CD;
	localparam logic [15:0] OPC_STORE_MODEL = 16'h0014;
	localparam logic [15:0] OPC_SUPERVISOR_CALL = 16'h0145;
	localparam logic [9:0] OPC_MICROSTORE_PREFIX = 10'h00E;
	// ----------------------------------------
	// fields, sizes, reset values
	// ----------------------------------------
	localparam logic [7:0] SVC_FAULT_VECTOR = 8'h0C;
	localparam int PAGE_OFFSET_BITS = 10;
	localparam logic [15:0] PAGE_TABLE_BASE = 16'h0000;
	localparam int PTE_FAULT_BIT = 15;
	localparam int KEY_DISPATCH_BIT = 0;
	localparam logic [15:0] MODALS_RESET = 16'h0040;
	localparam logic [4:0] SAVE_AREA_LAST = 5'h1A;
	localparam logic [4:0] STATUS_LAST = 5'h03;
	localparam logic [4:0] MODEL_LAST = 5'h07;
	localparam logic [4:0] XB_SLOT_HI = 5'h19;
	localparam logic [4:0] XB_SLOT_LO = 5'h1A;
	// arbitrary values: identification only
	localparam logic [31:0] MODEL_CODE = 32'h0000_0A5A;
	localparam logic [31:0] MICROCODE_REVISION = 32'h0000_0101;
	// ----------------------------------------
	// register port map
	// ----------------------------------------
	localparam logic [7:0] REG_STATUS = 8'h00;
	localparam logic [7:0] REG_CONFIG = 8'h04;
	localparam logic [7:0] REG_PID = 8'h08;
	localparam logic [7:0] REG_MODALS = 8'h0C;
	localparam logic [7:0] REG_KEYS = 8'h10;
	localparam logic [7:0] REG_CS_CONTROL = 8'h14;
	localparam int CFG_SEGMENTED_BIT = 0;
	localparam int CFG_EXCHANGE_BIT = 1;
	localparam logic [1:0] CONFIG_RESET = 2'h1;

	typedef struct packed {
		logic req;
		logic we;
		logic [15:0] addr;
		logic [15:0] wdata;
	} mem_bus_t;

	typedef struct packed {
		logic we;
		logic [7:0] addr;
		logic [15:0] data;
	} cs_write_t;

	typedef struct packed {
		logic we;
		logic [5:0] tag;
		logic [15:0] frame;
	} iot_write_t;

	typedef enum logic [3:0] {
		OP_NONE = 4'b0000, OP_STATUS = 4'b0001, OP_RESTORE = 4'b0010, OP_SAVE = 4'b0011,
		OP_MODEL = 4'b0100, OP_CS_LOAD = 4'b0101, OP_IOT = 4'b0110
	} op_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00, ST_MEM = 2'b01, ST_FIN = 2'b10, ST_MODAL = 2'b11
	} state_t;
endpackage

// [hw/machine_control_instruction_unit.sv]
// privileged machine-control instruction execution unit
//
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/1ps

// Operation
// - io translation tag from L page only
// - faulting translation raises page fault
// - process id from A bits 1-12
// - leave paging, jump to effective address
// - leave paging, jump into control store
// - status load only in ring zero
// - four-word status: pc, keys, then modals
// - dispatcher bit selects dispatch or continue
// - modals take effect immediately always
// - master clear selects register set 2
// - control store loads from temporary base
// - no-op only advances program counter
// - purge all if L top bit
// - restore registers from save-area layout
// - save only nonzero registers, base always
// - 27-word area, mask bit layout
// - store model: model, revision, reserved
// - supervisor call: interrupt or fault 14
// - 0016xx opcodes are microcode entrances
module machine_control_instruction_unit (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// instruction issue
	input wire logic instr_valid,
	output logic instr_ready,
	input wire logic [15:0] opcode,
	input wire logic [15:0] operand,
	input wire logic [15:0] reg_a,
	input wire logic [15:0] reg_b,
	input wire logic [15:0] temporary_base,
	input wire logic [1:0] ring,
	input wire logic [26:0][15:0] save_image,
	input wire logic paging_on,
	output logic done,
	// memory port
	output mctl_pkg::mem_bus_t mem,
	input wire logic mem_ack,
	input wire logic [15:0] mem_rdata,
	// effects on the processor
	output logic pc_advance,
	output logic pc_load,
	output logic [31:0] pc_value,
	output logic dispatch_enter,
	output logic modal_load,
	output logic [15:0] keys,
	output logic [15:0] modals,
	output logic [11:0] process_identifier_register,
	output logic paging_enabled,
	output logic cs_jump,
	output logic [15:0] cs_jump_addr,
	output mctl_pkg::cs_write_t cs_wr,
	output mctl_pkg::iot_write_t iot_wr,
	output logic purge_all,
	output logic purge_page,
	output logic [15:0] purge_page_number,
	output logic restore_load,
	output logic [26:0][15:0] restore_image,
	output logic restricted_fault,
	output logic page_fault,
	output logic svc_interrupt,
	output logic svc_fault,
	output logic [7:0] fault_vector,
	output logic microcode_entrance,
	output logic [5:0] microcode_entry,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata
);
	import mctl_pkg::*;

	state_t state_reg;
	op_t op_reg;
	logic [4:0] widx_reg;
	logic [4:0] last_reg;
	logic [15:0] base_reg;
	logic [15:0] rbuf [0:26];
	logic [15:0] cs_control_reg;
	logic [1:0] config_reg;
	logic [31:0] l_reg;
	logic [15:0] save_mask;
	logic [5:0] grp_nz;
	logic [2:0] slot_grp;
	logic skip;
	logic is_restricted;
	logic take;
	logic step;

	// ----------------------------------------
	// decode
	// ----------------------------------------
	assign instr_ready = (state_reg == ST_IDLE);
	assign take = instr_valid && instr_ready;
	always_comb begin
		case (opcode)
			OPC_LOAD_IO_TRANSLATION, OPC_LOAD_PROCESS_IDENTIFIER, OPC_LEAVE_PAGING_JUMP,
			OPC_LOAD_STATUS_WORD, OPC_LOAD_CONTROL_STORE, OPC_CONTROL_STORE_CONTROL,
			OPC_TRANSLATION_PURGE, OPC_STORE_MODEL: is_restricted = 1'b1;
			default: is_restricted = 1'b0;
		endcase
	end

	// save-area slot to register group: 1 fac1, 2 fac0, 3 X, 4 Y/S, 5 E, 6 L
	function automatic logic [2:0] group_of(input logic [4:0] idx);
		if (idx >= 5'h01 && idx <= 5'h04) begin
			return 3'h1;
		end else if (idx >= 5'h05 && idx <= 5'h08) begin
			return 3'h2;
		end else if (idx == 5'h09 || idx == 5'h0A) begin
			return 3'h3;
		end else if (idx == 5'h0D || idx == 5'h0E) begin
			return 3'h4;
		end else if (idx == 5'h11 || idx == 5'h12) begin
			return 3'h5;
		end else if (idx == 5'h13 || idx == 5'h14) begin
			return 3'h6;
		end
		return 3'h0;
	endfunction

	genvar g;
	generate
		for (g = 0; g < 6; g++) begin : gen_group
			always_comb begin
				grp_nz[g] = 1'b0;
				for (int i = 0; i < 27; i++) begin
					if (group_of(5'(i)) == 3'(g + 1) && save_image[i] != 16'h0000) begin
						grp_nz[g] = 1'b1;
					end
				end
			end
		end
	endgenerate

	// mask bit n (1 = msb) sits at [16-n]; bits 1-4 stay zero
	assign save_mask = {4'h0, {2{grp_nz[0]}}, {2{grp_nz[1]}}, grp_nz[2], 1'b0,
		grp_nz[3], 1'b0, grp_nz[4], 1'b0, {2{grp_nz[5]}}};

	// ----------------------------------------
	// memory sequencer
	// ----------------------------------------
	assign slot_grp = group_of(widx_reg);
	// zero registers below the XB slots leave their slots untouched; pads are never written
	assign skip = (op_reg == OP_SAVE) && widx_reg != 5'h00 && widx_reg < XB_SLOT_HI &&
		(slot_grp == 3'h0 || !grp_nz[slot_grp - 3'h1]);
	assign step = (state_reg == ST_MEM) && (skip || mem_ack);

	always_comb begin
		mem.req = (state_reg == ST_MEM) && !skip;
		mem.we = (op_reg == OP_SAVE) || (op_reg == OP_MODEL);
		mem.addr = base_reg + {11'h000, widx_reg};
		case (op_reg)
			OP_SAVE: mem.wdata = (widx_reg == 5'h00) ? save_mask : save_image[widx_reg];
			OP_MODEL: begin
				case (widx_reg)
					5'h00: mem.wdata = MODEL_CODE[31:16];
					5'h01: mem.wdata = MODEL_CODE[15:0];
					5'h02: mem.wdata = MICROCODE_REVISION[31:16];
					5'h03: mem.wdata = MICROCODE_REVISION[15:0];
					default: mem.wdata = 16'h0000;
				endcase
			end
			default: mem.wdata = 16'h0000;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= ST_IDLE;
			op_reg <= OP_NONE;
			widx_reg <= 5'h00;
			last_reg <= 5'h00;
			base_reg <= 16'h0000;
			l_reg <= 32'h0000_0000;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					widx_reg <= 5'h00;
					l_reg <= {reg_a, reg_b};
					if (take && !(is_restricted && ring != 2'h0)) begin
						state_reg <= ST_MEM;
						case (opcode)
							OPC_LOAD_STATUS_WORD: begin
								op_reg <= OP_STATUS;
								last_reg <= STATUS_LAST;
								base_reg <= operand;
							end
							OPC_REGISTER_RESTORE: begin
								op_reg <= OP_RESTORE;
								last_reg <= SAVE_AREA_LAST;
								base_reg <= operand;
							end
							OPC_REGISTER_SAVE: begin
								op_reg <= OP_SAVE;
								last_reg <= SAVE_AREA_LAST;
								base_reg <= operand;
							end
							OPC_STORE_MODEL: begin
								op_reg <= OP_MODEL;
								last_reg <= MODEL_LAST;
								base_reg <= temporary_base;
							end
							OPC_LOAD_CONTROL_STORE: begin
								op_reg <= OP_CS_LOAD;
								last_reg <= cs_control_reg[4:0];
								base_reg <= temporary_base;
							end
							OPC_LOAD_IO_TRANSLATION: begin
								op_reg <= OP_IOT;
								last_reg <= 5'h00;
								base_reg <= PAGE_TABLE_BASE + {10'h000, operand[15:10]};
							end
							default: begin
								op_reg <= OP_NONE;
								state_reg <= ST_IDLE;
							end
						endcase
					end
				end
				ST_MEM: begin
					if (step) begin
						widx_reg <= widx_reg + 5'h01;
						if (widx_reg == last_reg) begin
							state_reg <= ST_FIN;
						end
					end
				end
				ST_FIN: begin
					state_reg <= (op_reg == OP_STATUS) ? ST_MODAL : ST_IDLE;
				end
				ST_MODAL: begin
					state_reg <= ST_IDLE;
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// read words land here; control-store blocks may run past 27 words, so cap the index
	always_ff @(posedge clk) begin
		if (state_reg == ST_MEM && mem_ack && !mem.we && widx_reg <= SAVE_AREA_LAST) begin
			rbuf[widx_reg] <= mem_rdata;
		end
	end

	// ----------------------------------------
	// single-cycle instructions
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pc_advance <= 1'b0;
			restricted_fault <= 1'b0;
			purge_all <= 1'b0;
			purge_page <= 1'b0;
			purge_page_number <= 16'h0000;
			svc_interrupt <= 1'b0;
			svc_fault <= 1'b0;
			fault_vector <= 8'h00;
			microcode_entrance <= 1'b0;
			microcode_entry <= 6'h00;
			cs_jump <= 1'b0;
			cs_jump_addr <= 16'h0000;
		end else begin
			pc_advance <= take && opcode == OPC_NOP;
			restricted_fault <= take && is_restricted && ring != 2'h0;
			purge_all <= take && opcode == OPC_TRANSLATION_PURGE && ring == 2'h0 && reg_a[15];
			purge_page <= take && opcode == OPC_TRANSLATION_PURGE && ring == 2'h0 && !reg_a[15];
			if (take && opcode == OPC_TRANSLATION_PURGE) begin
				purge_page_number <= reg_b;
			end
			svc_interrupt <= take && opcode == OPC_SUPERVISOR_CALL &&
				!(config_reg[CFG_SEGMENTED_BIT] && config_reg[CFG_EXCHANGE_BIT]);
			svc_fault <= take && opcode == OPC_SUPERVISOR_CALL &&
				config_reg[CFG_SEGMENTED_BIT] && config_reg[CFG_EXCHANGE_BIT];
			if (take && opcode == OPC_SUPERVISOR_CALL) begin
				fault_vector <= SVC_FAULT_VECTOR;
			end
			microcode_entrance <= take && opcode[15:6] == OPC_MICROSTORE_PREFIX;
			if (take && opcode[15:6] == OPC_MICROSTORE_PREFIX) begin
				microcode_entry <= opcode[5:0];
			end
			cs_jump <= take && opcode == OPC_LEAVE_PAGING_JUMP_CONTROL_STORE;
			if (take && opcode == OPC_LEAVE_PAGING_JUMP_CONTROL_STORE) begin
				cs_jump_addr <= operand;
			end
		end
	end

	// paging: enabled from elsewhere, both leave-paging jumps turn it off
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			paging_enabled <= 1'b0;
		end else if (take && ((ring == 2'h0 && opcode == OPC_LEAVE_PAGING_JUMP) ||
			opcode == OPC_LEAVE_PAGING_JUMP_CONTROL_STORE)) begin
			paging_enabled <= 1'b0;
		end else if (paging_on) begin
			paging_enabled <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			process_identifier_register <= 12'h000;
			cs_control_reg <= 16'h0000;
		end else if (take && ring == 2'h0) begin
			if (opcode == OPC_LOAD_PROCESS_IDENTIFIER) begin
				process_identifier_register <= reg_a[15:4];
			end
			if (opcode == OPC_CONTROL_STORE_CONTROL) begin
				cs_control_reg <= reg_a;
			end
		end
	end

	// ----------------------------------------
	// completion of multi-word instructions
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pc_load <= 1'b0;
			pc_value <= 32'h0000_0000;
			keys <= 16'h0000;
			modals <= MODALS_RESET;
			modal_load <= 1'b0;
			dispatch_enter <= 1'b0;
		end else begin
			pc_load <= 1'b0;
			modal_load <= 1'b0;
			dispatch_enter <= 1'b0;
			if (take && ring == 2'h0 && opcode == OPC_LEAVE_PAGING_JUMP) begin
				pc_load <= 1'b1;
				pc_value <= {16'h0000, operand};
			end
			if (state_reg == ST_FIN && op_reg == OP_STATUS) begin
				keys <= rbuf[2];
				pc_value <= {rbuf[0], rbuf[1]};
				pc_load <= !rbuf[2][KEY_DISPATCH_BIT];
			end
			if (state_reg == ST_MODAL) begin
				// register-set bits are software's to preserve
				modals <= rbuf[3];
				modal_load <= 1'b1;
				dispatch_enter <= keys[KEY_DISPATCH_BIT];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			restore_load <= 1'b0;
			restore_image <= '0;
			page_fault <= 1'b0;
			iot_wr <= '0;
			cs_wr <= '0;
		end else begin
			restore_load <= state_reg == ST_FIN && op_reg == OP_RESTORE;
			if (state_reg == ST_FIN && op_reg == OP_RESTORE) begin
				for (int i = 0; i < 27; i++) begin
					// slots of registers saved as zero hold stale data
					if (5'(i) >= XB_SLOT_HI || (group_of(5'(i)) != 3'h0 &&
						save_mask_of(rbuf[0], group_of(5'(i))))) begin
						restore_image[i] <= rbuf[i];
					end else begin
						restore_image[i] <= 16'h0000;
					end
				end
			end
			page_fault <= state_reg == ST_FIN && op_reg == OP_IOT && rbuf[0][PTE_FAULT_BIT];
			iot_wr.we <= state_reg == ST_FIN && op_reg == OP_IOT && !rbuf[0][PTE_FAULT_BIT];
			if (state_reg == ST_FIN && op_reg == OP_IOT) begin
				iot_wr.tag <= l_reg[15:PAGE_OFFSET_BITS];
				iot_wr.frame <= rbuf[0];
			end
			cs_wr.we <= state_reg == ST_MEM && op_reg == OP_CS_LOAD && mem_ack;
			if (state_reg == ST_MEM && mem_ack) begin
				cs_wr.addr <= cs_control_reg[15:8] + {3'h0, widx_reg};
				cs_wr.data <= mem_rdata;
			end
		end
	end

	function automatic logic save_mask_of(input logic [15:0] m, input logic [2:0] grp);
		case (grp)
			3'h1: return m[11];
			3'h2: return m[9];
			3'h3: return m[7];
			3'h4: return m[5];
			3'h5: return m[3];
			3'h6: return m[1];
			default: return 1'b0;
		endcase
	endfunction

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			done <= 1'b0;
		end else begin
			done <= (state_reg == ST_IDLE && take && !(ring == 2'h0 &&
				(opcode == OPC_LOAD_STATUS_WORD || opcode == OPC_REGISTER_RESTORE ||
				opcode == OPC_REGISTER_SAVE || opcode == OPC_STORE_MODEL ||
				opcode == OPC_LOAD_CONTROL_STORE || opcode == OPC_LOAD_IO_TRANSLATION)) &&
				!(ring != 2'h0 && opcode == OPC_REGISTER_RESTORE) &&
				!(ring != 2'h0 && opcode == OPC_REGISTER_SAVE)) ||
				(state_reg == ST_FIN && op_reg != OP_STATUS) || state_reg == ST_MODAL;
		end
	end

	// ----------------------------------------
	// register port
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			config_reg <= CONFIG_RESET;
		end else if (reg_wr && reg_addr == REG_CONFIG) begin
			config_reg <= reg_wdata[1:0];
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			case (reg_addr)
				REG_STATUS: reg_rdata <= {24'h000000, paging_enabled, op_reg, 1'b0, state_reg};
				REG_CONFIG: reg_rdata <= {30'h00000000, config_reg};
				REG_PID: reg_rdata <= {20'h00000, process_identifier_register};
				REG_MODALS: reg_rdata <= {16'h0000, modals};
				REG_KEYS: reg_rdata <= {16'h0000, keys};
				REG_CS_CONTROL: reg_rdata <= {16'h0000, cs_control_reg};
				default: reg_rdata <= 32'h0000_0000;
			endcase
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence s_status_pc;
		state_reg == ST_FIN && op_reg == OP_STATUS;
	endsequence
	sequence s_status_modal;
		state_reg == ST_MODAL ##1 modal_load;
	endsequence

	AST_PID_BITS: assert property (@(posedge clk) disable iff (!rst_b)
		take && ring == 2'h0 && opcode == OPC_LOAD_PROCESS_IDENTIFIER
		|=> process_identifier_register == $past(reg_a[15:4]))
		else $error("process id not taken from A bits 1-12");
	AST_RESTRICTED: assert property (@(posedge clk) disable iff (!rst_b)
		take && is_restricted && ring != 2'h0 |=> restricted_fault && state_reg == ST_IDLE)
		else $error("restricted instruction ran outside ring zero");
	AST_STATUS_RING: assert property (@(posedge clk) disable iff (!rst_b)
		take && opcode == OPC_LOAD_STATUS_WORD && ring != 2'h0 |=> !mem.req [*3])
		else $error("status load started outside ring zero");
	AST_PURGE: assert property (@(posedge clk) disable iff (!rst_b)
		take && ring == 2'h0 && opcode == OPC_TRANSLATION_PURGE
		|=> purge_all == $past(reg_a[15]) && purge_page != purge_all)
		else $error("purge kind does not follow L top bit");
	AST_SVC_FAULT: assert property (@(posedge clk) disable iff (!rst_b)
		svc_fault |-> fault_vector == 8'h0C && !svc_interrupt)
		else $error("supervisor fault without vector 14");
	AST_ENTRANCE: assert property (@(posedge clk) disable iff (!rst_b)
		take && opcode[15:6] == 10'h00E |=> microcode_entrance && !restricted_fault)
		else $error("microstore opcode not taken as entrance");
	AST_STATUS_ORDER: assert property (@(posedge clk) disable iff (!rst_b)
		s_status_pc |=> s_status_modal)
		else $error("modals not loaded right after pc and keys");
	AST_DISPATCH: assert property (@(posedge clk) disable iff (!rst_b)
		modal_load |-> dispatch_enter == keys[0] && !$past(pc_load) == keys[0])
		else $error("dispatcher choice does not follow key bit 16");
	AST_SAVE_SKIP: assert property (@(posedge clk) disable iff (!rst_b)
		mem.req && op_reg == OP_SAVE && widx_reg != 5'h00 && widx_reg < 5'h19
		|-> slot_grp != 3'h0 && save_mask_of(save_mask, slot_grp))
		else $error("zero register written to save area");
	AST_PAGE_FAULT: assert property (@(posedge clk) disable iff (!rst_b)
		page_fault |-> !iot_wr.we)
		else $error("translation loaded despite fault bit");
	AST_NOP: assert property (@(posedge clk) disable iff (!rst_b)
		take && opcode == OPC_NOP |=> pc_advance && !pc_load && $stable(keys))
		else $error("no-op did more than advance");
endmodule // machine_control_instruction_unit

// [verification/tb_top.sv]
// self-checking bench for the machine-control instruction unit
`timescale 1ns/1ps
module tb_top;
	import mctl_pkg::*;
	logic clk, rst_b, instr_valid, instr_ready, paging_on, done, mem_ack, reg_wr, reg_rd, rd_d;
	logic [15:0] opcode, operand, reg_a, reg_b, temporary_base, mem_rdata, seed, v, w3;
	logic [15:0] keys, modals, cs_jump_addr, purge_page_number, sent;
	logic [1:0] ring;
	logic [26:0][15:0] save_image, restore_image;
	logic [7:0] reg_addr, fault_vector;
	logic [31:0] reg_wdata, reg_rdata, pc_value;
	logic [11:0] pid;
	logic [5:0] microcode_entry;
	logic pc_advance, pc_load, dispatch_enter, modal_load, paging_enabled, cs_jump, purge_all;
	logic purge_page, restore_load, restricted_fault, page_fault, svc_interrupt, svc_fault;
	logic microcode_entrance;
	mem_bus_t mem;
	cs_write_t cs_wr;
	iot_write_t iot_wr;
	logic [15:0] mem_img [64];
	logic [47:0] exp_q [$];
	int error_cnt, total_checks;

	machine_control_instruction_unit u_dut (.clk(clk), .rst_b(rst_b),
		.instr_valid(instr_valid), .instr_ready(instr_ready), .opcode(opcode),
		.operand(operand), .reg_a(reg_a), .reg_b(reg_b), .temporary_base(temporary_base),
		.ring(ring), .save_image(save_image), .paging_on(paging_on), .done(done), .mem(mem),
		.mem_ack(mem_ack), .mem_rdata(mem_rdata), .pc_advance(pc_advance), .pc_load(pc_load),
		.pc_value(pc_value), .dispatch_enter(dispatch_enter), .modal_load(modal_load),
		.keys(keys), .modals(modals), .process_identifier_register(pid),
		.paging_enabled(paging_enabled), .cs_jump(cs_jump), .cs_jump_addr(cs_jump_addr),
		.cs_wr(cs_wr), .iot_wr(iot_wr), .purge_all(purge_all), .purge_page(purge_page),
		.purge_page_number(purge_page_number), .restore_load(restore_load),
		.restore_image(restore_image), .restricted_fault(restricted_fault),
		.page_fault(page_fault), .svc_interrupt(svc_interrupt), .svc_fault(svc_fault),
		.fault_vector(fault_vector), .microcode_entrance(microcode_entrance),
		.microcode_entry(microcode_entry), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic test_done();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic check(input logic [47:0] seen, input logic [47:0] expd);
		total_checks++;
		if (seen !== expd) begin
			error_cnt++;
			$display("FAIL %0t: seen %h expected %h", $time, seen, expd);
		end
	endtask

	task automatic take(input logic [47:0] seen);
		if (exp_q.size() == 0) check(seen, 48'hFFFF_FFFF_FFFF);
		else check(seen, exp_q.pop_front());
	endtask

	task automatic note(input logic [7:0] k, input logic [39:0] d);
		exp_q.push_back({k, d});
	endtask

	task automatic rnd();
		seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
		v = seed;
	endtask

	// waits are bounded so a stuck unit ends the run
	task automatic issue(input logic [15:0] op, input logic [15:0] opd, input logic [1:0] rg);
		int n;
		n = 0;
		@(posedge clk);
		instr_valid <= 1'b1;
		opcode <= op;
		operand <= opd;
		ring <= rg;
		@(posedge clk);
		instr_valid <= 1'b0;
		@(posedge clk);
		#1;
		while (instr_ready !== 1'b1 && n < 100) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n == 100) begin
			error_cnt++;
			$display("FAIL %0t: unit stays busy", $time);
			test_done();
		end
		repeat (2) @(posedge clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] d);
		note(8'h0A, {8'h00, d});
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		repeat (2) @(posedge clk);
	endtask

	// ----------------------------------------
	// memory responder and result watcher
	// ----------------------------------------
	always @(posedge clk) begin
		mem_ack <= mem.req && !mem_ack;
		// released data bus inverts every cycle rather than holding the last word
		mem_rdata <= mem.req ? mem_img[mem.addr[5:0]] : ~mem_rdata;
		if (mem.req && mem.we && mem_ack) mem_img[mem.addr[5:0]] <= mem.wdata;
		rd_d <= reg_rd;
	end

	always @(negedge clk) if (rst_b) begin
		if (pc_advance) take({8'h01, 40'h0});
		if (pc_advance) check(48'(done), 48'h1);
		if (cs_wr.we) take({8'h0E, 16'h0, cs_wr.addr, cs_wr.data});
		if (restore_load) take({8'h0F, restore_image[1][7:0], restore_image[9],
			restore_image[26]});
		if (restricted_fault) take({8'h02, 40'h0});
		if (purge_all) take({8'h03, 40'h0});
		if (purge_page) take({8'h04, 24'h0, purge_page_number});
		if (microcode_entrance) take({8'h05, 34'h0, microcode_entry});
		if (svc_interrupt) take({8'h06, 40'h0});
		if (svc_fault) take({8'h07, 32'h0, fault_vector});
		if (pc_load) take({8'h08, 24'h0, pc_value[15:0]});
		if (modal_load) take({8'h09, 23'h0, dispatch_enter, modals});
		if (rd_d) take({8'h0A, 8'h0, reg_rdata});
		if (cs_jump) take({8'h0B, 24'h0, cs_jump_addr});
		if (page_fault) take({8'h0C, 40'h0});
		if (iot_wr.we) take({8'h0D, 18'h0, iot_wr.frame, iot_wr.tag});
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{rst_b, instr_valid, paging_on, mem_ack, reg_wr, reg_rd, rd_d} = '0;
		{opcode, operand, reg_a, reg_b, temporary_base, mem_rdata, ring} = '0;
		{reg_addr, reg_wdata, save_image} = '0;
		error_cnt = 0;
		total_checks = 0;
		seed = 16'h0050;
		for (int i = 0; i < 64; i++) begin
			rnd();
			mem_img[i] = v | 16'h0001;
		end
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		rd(REG_MODALS, 32'h0000_0040);
		rd(8'h30, 32'h0000_0000);
		note(8'h01, 40'h0);
		issue(OPC_NOP, 16'h0000, 2'h0);
		rnd();
		reg_a <= v;
		issue(OPC_LOAD_PROCESS_IDENTIFIER, 16'h0000, 2'h0);
		rd(REG_PID, {20'h0, v[15:4]});
		note(8'h02, 40'h0);
		issue(OPC_LOAD_PROCESS_IDENTIFIER, 16'h0000, 2'h1);
		note(8'h02, 40'h0);
		issue(OPC_LOAD_STATUS_WORD, 16'h0008, 2'h3);
		reg_a <= 16'h8000;
		note(8'h03, 40'h0);
		issue(OPC_TRANSLATION_PURGE, 16'h0000, 2'h0);
		rnd();
		reg_a <= 16'h0000;
		reg_b <= v;
		note(8'h04, {24'h0, v});
		issue(OPC_TRANSLATION_PURGE, 16'h0000, 2'h0);
		for (int e = 0; e < 64; e += 21) begin
			note(8'h05, 40'(e));
			issue({OPC_MICROSTORE_PREFIX, 6'(e)}, 16'h0000, 2'h0);
		end
		note(8'h06, 40'h0);
		issue(OPC_SUPERVISOR_CALL, 16'h0000, 2'h0);
		wr(REG_CONFIG, 32'h0000_0003);
		note(8'h07, 40'h0C);
		issue(OPC_SUPERVISOR_CALL, 16'h0000, 2'h0);
		@(posedge clk);
		paging_on <= 1'b1;
		@(posedge clk);
		paging_on <= 1'b0;
		@(posedge clk);
		check(48'(paging_enabled), 48'h1);
		rnd();
		note(8'h08, {24'h0, v});
		issue(OPC_LEAVE_PAGING_JUMP, v, 2'h0);
		check(48'(paging_enabled), 48'h0);
		note(8'h0B, {24'h0, v});
		issue(OPC_LEAVE_PAGING_JUMP_CONTROL_STORE, v, 2'h0);
		for (int d = 0; d < 2; d++) begin
			// keys: save-done clear; modals: register-set bits kept at set 2
			mem_img[10] = {mem_img[10][15:2], 1'b0, 1'(d)};
			w3 = {mem_img[11][15:8], 3'b010, mem_img[11][4:0]};
			mem_img[11] = w3;
			if (d == 0) note(8'h08, {24'h0, mem_img[9]});
			note(8'h09, {23'h0, 1'(d), w3});
			issue(OPC_LOAD_STATUS_WORD, 16'h0008, 2'h0);
			check(48'(keys), 48'(mem_img[10]));
		end
		check(48'(pc_value[31:16]), 48'(mem_img[8]));
		reg_b <= 16'hA400;
		mem_img[1] = 16'h8000;
		note(8'h0C, 40'h0);
		issue(OPC_LOAD_IO_TRANSLATION, 16'h0400, 2'h0);
		mem_img[1] = 16'h0005;
		note(8'h0D, {18'h0, 16'h0005, 6'h29});
		issue(OPC_LOAD_IO_TRANSLATION, 16'h0400, 2'h0);
		rnd();
		sent = mem_img[8'h21];
		save_image[9] <= v;
		save_image[25] <= 16'h0123;
		save_image[26] <= 16'h0456;
		issue(OPC_REGISTER_SAVE, 16'h0020, 2'h0);
		check(48'(mem_img[8'h20]), 48'h0080);
		check(48'(mem_img[8'h29]), 48'(v));
		check(48'(mem_img[8'h21]), 48'(sent));
		check(48'(mem_img[8'h3A]), 48'h0456);
		note(8'h0F, {8'h00, v, 16'h0456});
		issue(OPC_REGISTER_RESTORE, 16'h0020, 2'h0);
		temporary_base <= 16'h0010;
		mem_img[8'h10] = 16'h0000;
		mem_img[8'h11] = 16'h0000;
		issue(OPC_STORE_MODEL, 16'h0000, 2'h0);
		check(48'({mem_img[8'h10], mem_img[8'h11]}), 48'(MODEL_CODE));
		check(48'({mem_img[8'h12], mem_img[8'h13]}), 48'(MICROCODE_REVISION));
		reg_a <= 16'h0301;
		issue(OPC_CONTROL_STORE_CONTROL, 16'h0000, 2'h0);
		note(8'h0E, {16'h0, 8'h03, MODEL_CODE[31:16]});
		note(8'h0E, {16'h0, 8'h04, MODEL_CODE[15:0]});
		issue(OPC_LOAD_CONTROL_STORE, 16'h0000, 2'h0);
		repeat (5) @(posedge clk);
		check(48'(exp_q.size()), 48'h0);
		test_done();
	end
endmodule // tb_top
